// >>> hw/bwb_pkg.sv
/*
  Shared constants and carrier types for the bus watch break unit.
  Assumes one bus clock domain and a processor bus with active-low selects.
*/
package bwb_pkg;
  // Bus widths
  localparam int ADDR_W   = 24;
  localparam int DATA_W   = 32;
  localparam int NSEL     = 10;   // Watched select lines, dual-use port lines included
  localparam int NCOMB    = 6;    // Bus break combinations
  localparam int NRANGE   = 2;    // Address-range breaks
  // Select line indices inside the watched vector
  localparam logic [3:0] SEL_PORT_A  = 4'h8;
  localparam logic [3:0] SEL_PORT_B  = 4'h9;
  localparam logic [3:0] SEL_DEFAULT = 4'h5;  // Area nine among areas four to nine
  // Register window decode
  localparam logic [11:0] WIN_MASK    = 12'hfff;
  localparam logic [2:0]  PAGE_TOP    = 3'h0;
  localparam logic [2:0]  PAGE_AREA   = 3'h1;
  localparam logic [2:0]  PAGE_BUS    = 3'h2;
  localparam logic [2:0]  PAGE_RANGE  = 3'h3;
  localparam int          PAGE_LSB    = 9;
  localparam int          MAP_LSB     = 11;   // Offsets 0x800 up hold the map RAM
  localparam int          MAP_WORDS   = 2048;
  localparam int          MAP_AW      = 11;
  localparam int          BLK32K_LSB  = 15;   // 32KB granules
  localparam int          BLK32K_W    = 9;    // Address bits 23..15
  // Sampling delay
  localparam logic [1:0]  DELAY_DEF   = 2'h2;
  localparam int          DELAY_STEP_PS = 4000;
  localparam int          CLK_PERIOD_PS = 50000;
  localparam logic [1:0]  DELAY_CYC   = 2'(((int'(DELAY_DEF) * DELAY_STEP_PS)
                                           + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  // Watched bus cycle
  typedef struct packed {
    logic [NSEL-1:0]   sel_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic              rd_n;
    logic              wrl_n;
    logic              wrh_n;
  } bus_t;
  // One bus break combination
  typedef struct packed {
    logic              en;
    logic [NSEL:0]     sel;     // Top bit: unselected access
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] amask;   // Set bits compare
    logic [DATA_W-1:0] data;
    logic [DATA_W-1:0] dmask;
    logic              on_rd;
    logic              on_wr;
  } comb_t;
  // Match flags
  typedef struct packed {
    logic area;
    logic map;
    logic bus;
    logic range;
  } hit_t;
endpackage

// >>> hw/bwb_sampler.sv
/*
  Delayed sampler for the watched bus.
  Assumes the bus pins are asynchronous to the clock and settle within a cycle.
*/
`timescale 1ns/1ps
module bwb_sampler (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // Delay setting and pins
  input  wire logic [1:0]    delay_sel,
  input  wire bwb_pkg::bus_t pins,
  // Sampled bus
  output bwb_pkg::bus_t      bus
);
  bwb_pkg::bus_t meta;           // First stage, read only by stage two
  bwb_pkg::bus_t sync;           // Second stage
  bwb_pkg::bus_t dly;            // One extra stage for the longer settings
  bwb_pkg::bus_t next_bus;

  ////////////////////////////////////////////////////////////////////////////
  // Delay choice; reset leaves every stage at the idle all-ones bus
  always_comb begin
    // Short settings skip the extra stage; only safe with static memory
    next_bus = (delay_sel >= bwb_pkg::DELAY_DEF) ? dly : sync;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Synchroniser stages
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= '1;
      sync <= '1;
      dly  <= '1;
      bus  <= '1;
    end else begin
      meta <= pins;
      sync <= meta;
      dly  <= sync;
      bus  <= next_bus;
    end
  end
endmodule

// >>> hw/bus_watch_break_unit.sv
/*
  Bus watching breakpoint unit: decodes its own register window on the
  processor bus, checks each bus cycle against area, map, bus and range
  conditions and pulses a break line toward the debugger.
  Assumes the host keeps the wait states it needs for map RAM and
  registers, and that configuration strobes come from the same clock.
*/
// How it works
// - Break line floats, pulses low on break
// - Monitor copy of break pulse
// - Four match flags, high while matching; bus flag only on counted hit
// - Register window in area nine, switch movable
// - Registers in first 4KB, mirrored after
// - Higher addresses alias register space
// - Top and area-select register pages decoded
// - Bus and range register pages decoded
// - Break follows matching cycle by cycles
// - Unselected access counts dual-use lines
// - Low dual-use line blocks unselected break
// - Unselected area and map matching off unless enabled
// - Selectable sampling delay, default two
// - Data compared with fast page timing
// - Sequence needs gap between break points
// - Six masked bus combinations compared
// - Shared sixteen-bit hit counter delays break
// - Sequence counts only final condition hits
// - Map break on selected 32KB blocks
`timescale 1ns/1ps
module bus_watch_break_unit (
  // Clock and reset
  input  wire logic                             CORE_CLK,
  input  wire logic                             RST,
  // Watched processor bus pins
  input  wire bwb_pkg::bus_t                    BUS_PINS,
  // Configuration
  input  wire logic [3:0]                       AREA_SELECTION_SWITCH,
  input  wire logic [1:0]                       SAMPLE_DELAY,
  input  wire logic                             UNSELECTED_ENABLE,
  input  wire logic                             HIGH_STROBE_MASK,
  input  wire logic                             SEQUENTIAL_MODE,
  input  wire logic [bwb_pkg::NSEL:0]           AREA_BREAK_SEL,
  input  wire logic                             AREA_ON_RD,
  input  wire logic                             AREA_ON_WR,
  input  wire logic                             MAP_ENABLE,
  input  wire logic [bwb_pkg::NSEL:0]           MAP_BREAK_SEL,
  input  wire bwb_pkg::comb_t [bwb_pkg::NCOMB-1:0] COMB,
  input  wire logic [15:0]                      HIT_TARGET,
  input  wire logic [bwb_pkg::NRANGE-1:0]       RANGE_ENABLE,
  input  wire logic [bwb_pkg::NRANGE-1:0]       RANGE_OUTSIDE,
  input  wire logic [bwb_pkg::NRANGE-1:0][bwb_pkg::NSEL:0] RANGE_SEL,
  input  wire logic [bwb_pkg::NRANGE-1:0][bwb_pkg::ADDR_W-1:0] RANGE_LO,
  input  wire logic [bwb_pkg::NRANGE-1:0][bwb_pkg::ADDR_W-1:0] RANGE_HI,
  // Break line toward the debugger
  output logic                                  BREAK_OUTPUT_PIN_O,
  output logic                                  BREAK_OUTPUT_PIN_OE,
  output logic                                  BREAK_MONITOR_N,
  // Match flags, register window status and hit count
  output bwb_pkg::hit_t                         MATCH,
  output logic                                  REG_WINDOW_HIT,
  output logic [2:0]                            REG_PAGE,
  output logic [15:0]                           HIT_COUNT
);
  localparam int NC = bwb_pkg::NCOMB;

  bwb_pkg::bus_t   bus;            // Sampled bus cycle
  logic [3:0]      win_area;       // Latched area of the register window
  logic            map_ram [bwb_pkg::MAP_WORDS];
  logic            map_bit;        // Registered lookup
  logic            map_sel_q;      // Map select qualifier, aligned with lookup
  logic            prev_cycle;     // Cycle active last clock
  logic [NC-1:0]   prev_hit;       // Combination hits of the last clock
  logic [2:0]      seq_pos;
  logic [15:0]     hit_cnt;
  logic            armed;
  logic [2:0]      next_seq_pos;
  logic [15:0]     next_hit_cnt;
  logic            next_armed;
  logic            cycle, rd, wr, unsel;
  logic [NC-1:0]   comb_hit;
  bwb_pkg::hit_t   next_match;
  logic            bus_fire;
  logic [bwb_pkg::NSEL:0] sel_vec;
  logic            next_win_hit;   // Window decode of the sampled cycle
  logic [2:0]      next_page;      // Register page of the sampled cycle
  logic [bwb_pkg::MAP_AW-1:0] map_idx; // Map RAM entry of the 32KB block
  logic            pulse;          // New break event this clock

  ////////////////////////////////////////////////////////////////////////////
  // Area select test, with unselected access in the top bit
  function automatic logic sel_match(input logic [bwb_pkg::NSEL:0] want,
                                     input logic [bwb_pkg::NSEL:0] have);
    sel_match = |(want & have);
  endfunction

  bwb_sampler sampler (
    .clk       (CORE_CLK),
    .rst       (RST),
    .delay_sel (SAMPLE_DELAY),
    .pins      (BUS_PINS),
    .bus       (bus)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Cycle classification and matching
  always_comb begin
    rd    = ~bus.rd_n;
    // High strobe ignored when byte lanes share it
    wr    = ~bus.wrl_n | (~bus.wrh_n & ~HIGH_STROBE_MASK);
    cycle = rd | wr;
    // Dual-use lines are always in the vector
    unsel = cycle & (&bus.sel_n);
    sel_vec = {unsel, ~bus.sel_n};
    // Window hit: any address of the chosen area aliases the registers
    next_win_hit = 1'b0;
    next_page    = bus.addr[bwb_pkg::PAGE_LSB +: 3];
    if (cycle && !bus.sel_n[win_area]) begin
      next_win_hit = 1'b1;
    end
    // Block index zero-extended: the RAM holds more entries than blocks
    map_idx = '0;
    map_idx[bwb_pkg::BLK32K_W-1:0] = bus.addr[bwb_pkg::BLK32K_LSB +: bwb_pkg::BLK32K_W];
    next_match.area = cycle & sel_match(AREA_BREAK_SEL, sel_vec) &
                      ((rd & AREA_ON_RD) | (wr & AREA_ON_WR));
    if (unsel && !UNSELECTED_ENABLE) begin
      next_match.area = 1'b0;
    end
    // Map lookup registered in the same clock as its qualifier
    next_match.map = map_bit & map_sel_q & MAP_ENABLE;
    for (int i = 0; i < NC; i++) begin
      // Data compared on the sampled strobe window (fast page reads)
      comb_hit[i] = COMB[i].en & cycle & sel_match(COMB[i].sel, sel_vec) &
        (((bus.addr ^ COMB[i].addr) & COMB[i].amask) == '0) &
        (((bus.data ^ COMB[i].data) & COMB[i].dmask) == '0) &
        ((rd & COMB[i].on_rd) | (wr & COMB[i].on_wr));
    end
    next_match.bus = |comb_hit;
    next_match.range = 1'b0;
    for (int r = 0; r < bwb_pkg::NRANGE; r++) begin
      if (RANGE_ENABLE[r] && cycle && sel_match(RANGE_SEL[r], sel_vec) &&
          (((bus.addr >= RANGE_LO[r]) && (bus.addr <= RANGE_HI[r])) != RANGE_OUTSIDE[r])) begin
        next_match.range = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequence and hit counter
  always_comb begin
    next_seq_pos = seq_pos;
    next_hit_cnt = hit_cnt;
    next_armed   = armed;
    bus_fire     = 1'b0;
    if (SEQUENTIAL_MODE) begin
      // A repeat of last clock's hit is not a new break point
      if (comb_hit[seq_pos] && !(prev_cycle && prev_hit[seq_pos])) begin
        if (seq_pos == 3'(NC - 1) || !COMB[seq_pos + 3'h1].en) begin
          next_hit_cnt = hit_cnt + 16'h1;
          next_seq_pos = '0;
        end else begin
          next_seq_pos = seq_pos + 3'h1;
        end
      end
    end else if (|(comb_hit & ~prev_hit)) begin
      // One count per bus cycle, however many clocks it stands
      next_hit_cnt = hit_cnt + 16'h1;
    end
    if (next_hit_cnt != hit_cnt && next_hit_cnt >= HIT_TARGET && armed) begin
      bus_fire   = 1'b1;
      next_hit_cnt = '0;
    end
    // Only a rising flag or a counted hit breaks; a standing match would
    // otherwise hold the line low for the whole bus cycle
    pulse = (next_match.area & ~MATCH.area) | (next_match.map & ~MATCH.map) |
            (next_match.range & ~MATCH.range) | bus_fire;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Map RAM: written through the window, read for matching
  always_ff @(posedge CORE_CLK) begin
    if (next_win_hit && wr && bus.addr[bwb_pkg::MAP_LSB]) begin
      map_ram[bus.addr[bwb_pkg::MAP_AW-1:0]] <= bus.data[0];
    end
    map_bit <= map_ram[map_idx];
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers and outputs
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      win_area            <= bwb_pkg::SEL_DEFAULT;
      map_sel_q           <= 1'b0;
      prev_cycle          <= 1'b0;
      prev_hit            <= '0;
      seq_pos             <= '0;
      hit_cnt             <= '0;
      armed               <= 1'b0;
      MATCH               <= '0;
      BREAK_OUTPUT_PIN_O  <= 1'b0;
      BREAK_OUTPUT_PIN_OE <= 1'b0;
      BREAK_MONITOR_N     <= 1'b1;
      HIT_COUNT           <= '0;
      REG_WINDOW_HIT      <= 1'b0;
      REG_PAGE            <= '0;
    end else begin
      // Window status registered so the outputs come from flip-flops
      REG_WINDOW_HIT <= next_win_hit;
      REG_PAGE       <= next_page;
      // Switch picks the area; default is area nine
      win_area   <= AREA_SELECTION_SWITCH;
      map_sel_q  <= cycle & sel_match(MAP_BREAK_SEL, sel_vec) &
                    (!unsel | UNSELECTED_ENABLE);
      prev_cycle <= cycle;
      prev_hit   <= comb_hit;
      seq_pos    <= next_seq_pos;
      hit_cnt    <= next_hit_cnt;
      armed      <= 1'b1;
      HIT_COUNT  <= next_hit_cnt;
      MATCH      <= next_match;
      MATCH.bus  <= bus_fire;
      // One-clock low pulse, then release; back-to-back events merge
      BREAK_OUTPUT_PIN_OE <= pulse & ~BREAK_OUTPUT_PIN_OE;
      BREAK_MONITOR_N     <= ~(pulse & ~BREAK_OUTPUT_PIN_OE);
    end
  end
endmodule

// >>> bench/bwb_host_model.sv
/*
  Host bus model: runs one read or write cycle on the watched pins.
  Assumes one request at a time, raised for one clock while idle.
*/
`timescale 1ns/1ps
module bwb_host_model (
  // Clock and request
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic [3:0]  sel,
  input  wire logic [23:0] addr,
  input  wire logic [31:0] data,
  input  wire logic        wr,
  // Pins and status
  output bwb_pkg::bus_t    pins,
  output logic             busy
);
  logic [3:0] cnt;  // Clocks left in the cycle
  initial begin
    pins = '1;
    busy = 1'b0;
    cnt  = 4'h0;
  end
  ////////////////////////////////////////////////////////////////
  // Seven waits as the debugger uses; released lines show inverted values
  always @(posedge clk) begin
    if (go && !busy) begin
      pins.sel_n <= '1;
      // Static-memory cycles only, so no area needs a dynamic-memory mark
      if (sel != 4'hf) pins.sel_n[sel] <= 1'b0;
      pins.addr  <= addr;
      pins.data  <= data;
      pins.rd_n  <= wr;
      pins.wrl_n <= !wr;
      pins.wrh_n <= !wr;
      busy       <= 1'b1;
      cnt        <= 4'h7;
    end else if (busy && cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else if (busy) begin
      pins                                <= ~pins;
      pins.sel_n                          <= '1;
      {pins.rd_n, pins.wrl_n, pins.wrh_n} <= 3'h7;
      busy                                <= 1'b0;
    end
  end
endmodule

// >>> bench/bwb_properties.sv
/*
  Checker for the break line, match flags and hit counter.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
module bwb_properties (
  // Clock and reset
  input wire logic                   CORE_CLK,
  input wire logic                   RST,
  // Configuration
  input wire logic                   UNSELECTED_ENABLE,
  input wire logic [bwb_pkg::NSEL:0] AREA_BREAK_SEL,
  // Outputs
  input wire logic                   BREAK_OUTPUT_PIN_O,
  input wire logic                   BREAK_OUTPUT_PIN_OE,
  input wire logic                   BREAK_MONITOR_N,
  input wire bwb_pkg::hit_t          MATCH,
  input wire logic [15:0]            HIT_COUNT
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  AST_MONITOR_COPY: assert property (BREAK_OUTPUT_PIN_OE == !BREAK_MONITOR_N)
    else $error("monitor copy differs from break line");
  AST_DRIVE_LOW: assert property (BREAK_OUTPUT_PIN_OE |-> BREAK_OUTPUT_PIN_O == 1'b0)
    else $error("break line driven high");
  AST_ONE_CLOCK: assert property (BREAK_OUTPUT_PIN_OE |=> !BREAK_OUTPUT_PIN_OE)
    else $error("break pulse longer than one clock");
  // A break that lands in the clock after a pulse merges with it
  AST_AREA_BREAK: assert property ($rose(MATCH.area) |-> BREAK_OUTPUT_PIN_OE || $past(BREAK_OUTPUT_PIN_OE))
    else $error("area match without break");
  AST_BUS_BREAK: assert property (MATCH.bus |-> BREAK_OUTPUT_PIN_OE || $past(BREAK_OUTPUT_PIN_OE))
    else $error("bus fire without break");
  // Held config for four clocks lets the pipeline drain first
  AST_UNSEL_OFF: assert property ((!UNSELECTED_ENABLE && AREA_BREAK_SEL == 11'h400)[*4]
    |-> !MATCH.area) else $error("unselected match while disabled");
  AST_HIT_STEP: assert property (HIT_COUNT != $past(HIT_COUNT)
    |-> HIT_COUNT == $past(HIT_COUNT) + 16'h1 || HIT_COUNT == 16'h0)
    else $error("hit counter jumped");
  AST_RESET_IDLE: assert property (@(posedge CORE_CLK) disable iff (1'b0)
    RST && $past(RST) |-> !BREAK_OUTPUT_PIN_OE && BREAK_MONITOR_N) else $error("break active in reset");
endmodule

// >>> bench/tb.sv
/*
  Bench for the bus watch break unit: table of area cases, then decode,
  counter, sequence, map and delay cases by hand.
  Assumes the host model is the only driver of the watched pins.
*/
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    logic [3:0] sel; logic [10:0] asel; logic unsel; logic exp;
  } row_t;
  localparam row_t ROWS [5] = '{'{4'h0, 11'h001, 1'b0, 1'b1}, '{4'h3, 11'h001, 1'b0, 1'b0},
    '{4'hf, 11'h400, 1'b1, 1'b1}, '{4'hf, 11'h400, 1'b0, 1'b0}, '{4'h8, 11'h400, 1'b1, 1'b0}};
  localparam logic [23:0] OFFS [6] = '{24'h0, 24'h3ff, 24'h400, 24'h7ff, 24'h1600, 24'hf0200};
  logic clk = 0, rst = 1, go = 0, hwr = 0, unsel = 0, hmask = 1, seq = 0, mapen = 0;
  logic [3:0] hsel = 4'hf, sw = 4'h5;
  logic [23:0] haddr = 24'h0;
  logic [31:0] hdata = 32'h0;
  logic [1:0] dly = 2'h2, ren = 2'h0;
  logic [1:0][10:0] rsel = '0;
  logic [10:0] asel = 11'h0, msel = 11'h0;
  logic [15:0] tgt = 16'h1, hit;
  bwb_pkg::comb_t [5:0] comb = '0;
  bwb_pkg::bus_t pins;
  bwb_pkg::hit_t match, mt;
  logic busy, o, oe, mon, whit, brk, wh;
  logic [2:0] page, pg;
  int n_errors = 0, checks = 0, lat, lat0;
  always #25 clk = ~clk;
  bwb_host_model u_bwb_host_model (.clk(clk), .go(go), .sel(hsel), .addr(haddr),
    .data(hdata), .wr(hwr), .pins(pins), .busy(busy));
  bus_watch_break_unit u_bus_watch_break_unit (.CORE_CLK(clk), .RST(rst), .BUS_PINS(pins),
    .AREA_SELECTION_SWITCH(sw), .SAMPLE_DELAY(dly), .UNSELECTED_ENABLE(unsel),
    .HIGH_STROBE_MASK(hmask), .SEQUENTIAL_MODE(seq), .AREA_BREAK_SEL(asel),
    .AREA_ON_RD(1'b1), .AREA_ON_WR(hmask), .MAP_ENABLE(mapen), .MAP_BREAK_SEL(msel),
    .COMB(comb), .HIT_TARGET(tgt), .RANGE_ENABLE(ren), .RANGE_OUTSIDE(2'h0),
    .RANGE_SEL(rsel), .RANGE_LO('0), .RANGE_HI('0), .BREAK_OUTPUT_PIN_O(o),
    .BREAK_OUTPUT_PIN_OE(oe), .BREAK_MONITOR_N(mon), .MATCH(match),
    .REG_WINDOW_HIT(whit), .REG_PAGE(page), .HIT_COUNT(hit));
  ////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    if (n_errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // One host cycle, watching the break line for fifteen clocks
  task automatic op(input logic [3:0] s, input logic [23:0] a, input logic w);
    @(posedge clk);
    hsel  <= s;
    haddr <= a;
    hwr   <= w;
    go    <= 1'b1;
    @(posedge clk);
    go  <= 1'b0;
    brk = 1'b0;
    lat = 0;
    for (int i = 1; i < 16; i++) begin
      @(posedge clk);
      #1;
      if (i == 6) {wh, pg, mt} = {whit, page, match};
      if (oe === 1'b1 && !brk) {brk, lat} = {1'b1, i};
    end
    if (busy !== 1'b0) begin
      n_errors++;
      close_out();
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk({o, oe, mon, match, hit}, {3'h1, 4'h0, 16'h0});
    foreach (ROWS[k]) begin
      @(posedge clk);
      asel  <= ROWS[k].asel;
      unsel <= ROWS[k].unsel;
      op(ROWS[k].sel, 24'h000040, 1'b0);
      chk(brk, ROWS[k].exp);
      chk(lat <= 6, 1'b1);
    end
    @(posedge clk);
    asel <= 11'h0;
    foreach (OFFS[k]) begin
      op(4'h5, OFFS[k], 1'b0);
      chk({wh, pg}, {2'h2, OFFS[k][10:9]});
    end
    @(posedge clk);
    sw <= 4'h0;
    op(4'h5, 24'h0, 1'b0);
    chk(wh, 1'b0);
    op(4'h0, 24'h0, 1'b0);
    chk(wh, 1'b1);
    @(posedge clk);
    sw      <= 4'h5;
    tgt     <= 16'h3;
    comb[0] <= '{1'b1, 11'h001, 24'h100, 24'hffffff, 32'h0, 32'h0, 1'b1, 1'b0};
    comb[1] <= '{1'b1, 11'h001, 24'h200, 24'hffffff, 32'h0, 32'h0, 1'b1, 1'b0};
    for (int i = 0; i < 3; i++) begin
      op(4'h0, 24'h100, 1'b0);
      chk(brk, i == 2);
      if (i == 0) chk(hit, 16'h1);
    end
    @(posedge clk);
    seq <= 1'b1;
    tgt <= 16'h1;
    op(4'h0, 24'h200, 1'b0);
    chk(brk, 1'b0);
    op(4'h0, 24'h100, 1'b0);
    chk({brk, hit}, 17'h0);
    op(4'h0, 24'h200, 1'b0);
    chk(brk, 1'b1);
    @(posedge clk);
    comb  <= '0;
    mapen <= 1'b1;
    msel  <= 11'h001;
    // Entry 4 cleared with the idle data word, then entry 3 set
    op(4'h5, 24'h000804, 1'b1);
    @(posedge clk);
    hdata <= 32'h1;
    op(4'h5, 24'h000803, 1'b1);
    op(4'h0, 24'h018000, 1'b0);
    chk(brk, 1'b1);
    op(4'h0, 24'h020000, 1'b0);
    chk(brk, 1'b0);
    @(posedge clk);
    mapen <= 1'b0;
    asel  <= 11'h001;
    dly   <= 2'h0;
    op(4'h0, 24'h40, 1'b0);
    lat0 = lat;
    @(posedge clk);
    dly <= 2'h2;
    op(4'h0, 24'h40, 1'b0);
    chk(32'(lat), 32'(lat0 + 1));
    // Range zero covers address 0 only in area index 0
    @(posedge clk);
    asel    <= 11'h0;
    ren     <= 2'h1;
    rsel[0] <= 11'h001;
    op(4'h0, 24'h0, 1'b0);
    chk({brk, mt}, 5'h11);
    op(4'h0, 24'h40, 1'b0);
    chk({brk, mt}, 5'h00);
    close_out();
  end
endmodule
bind bus_watch_break_unit bwb_properties u_bwb_properties (.CORE_CLK(CORE_CLK), .RST(RST),
  .UNSELECTED_ENABLE(UNSELECTED_ENABLE), .AREA_BREAK_SEL(AREA_BREAK_SEL),
  .BREAK_OUTPUT_PIN_O(BREAK_OUTPUT_PIN_O), .BREAK_OUTPUT_PIN_OE(BREAK_OUTPUT_PIN_OE),
  .BREAK_MONITOR_N(BREAK_MONITOR_N), .MATCH(MATCH), .HIT_COUNT(HIT_COUNT));
